// ---- hw/xfer_ctrl_pkg.sv ----
// package for the event triggered transfer controller
// assumes a 32-bit memory bus and an axi4-lite register port
package xfer_ctrl_pkg;
  // register indexes, byte address is four times the index
  localparam logic [23:0] VECTOR_BASE_IDX = 24'hfffd80;
  localparam logic [23:0] SYSTEM_CONTROL_IDX = 24'hfffdc2;
  localparam logic [23:0] MODULE_STOP_A_IDX = 24'hfffdc8;
  localparam logic [23:0] TRANSFER_CONTROL_IDX = 24'hffff30;
  localparam logic [23:0] STATUS_IDX = 24'hffff34;
  // info layout indexes in memory (not reachable by the cpu)
  localparam logic [23:0] TRANSFER_MODE_A_IDX = 24'hff5000;
  localparam logic [23:0] SOURCE_POINTER_IDX = 24'hff5001;
  localparam logic [23:0] TRANSFER_MODE_B_IDX = 24'hff5004;
  localparam logic [23:0] DESTINATION_POINTER_IDX = 24'hff5005;
  // reset values and write masks
  localparam logic [31:0] VECTOR_BASE_RST = 32'h00000000;
  localparam logic [31:0] VECTOR_BASE_MASK = 32'h0ffff000;
  localparam logic [15:0] SYSTEM_CONTROL_RST = 16'h0000;
  localparam logic [15:0] MODULE_STOP_A_RST = 16'h0000;
  localparam logic [7:0] TRANSFER_CONTROL_RST = 8'h00;
  // field positions
  localparam int SHORT_ADDR_SELECT_BIT = 1;
  localparam int CONTROLLER_STOP_BIT = 12;
  localparam int INFO_READ_SKIP_BIT = 4;
  localparam int CHAIN_AFTER_RELOAD_BIT = 3;
  localparam int CHAIN_ENABLE_BIT = 7;
  localparam int CHAIN_CONDITION_BIT = 6;
  localparam int PER_TRANSFER_IRQ_BIT = 5;
  localparam int AREA_SIDE_SELECT_BIT = 4;
  // info words per channel
  localparam logic [2:0] INFO_WORDS_SHORT = 3'd3;
  localparam logic [2:0] INFO_WORDS_FULL = 3'd5;
  // transfer modes, sizes and pointer steps
  localparam logic [1:0] MODE_NORMAL = 2'b00;
  localparam logic [1:0] MODE_REPEAT = 2'b01;
  localparam logic [1:0] MODE_BLOCK = 2'b10;
  localparam logic [1:0] SIZE_BYTE = 2'b00;
  localparam logic [1:0] SIZE_WORD = 2'b01;
  localparam logic [1:0] STEP_INC = 2'b10;
  localparam logic [1:0] STEP_DEC = 2'b11;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VEC = 3'b001,
    ST_INFO = 3'b011,
    ST_XRD = 3'b010,
    ST_XWR = 3'b110,
    ST_WB = 3'b111,
    ST_DONE = 3'b101
  } state_t;

  // memory bus request, held until acknowledged
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  // activation source event towards interrupt logic
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } vec_evt_t;
endpackage : xfer_ctrl_pkg

// ---- hw/event_triggered_transfer_ctrl.sv ----
// event triggered transfer controller: fetch, move, write back, chain
// assumes activation and memory ports come from logic on i_ref_clk
//
// What this block does
// - mode word a bits 7:6 give transfer mode; 10 means block mode
// - mode word a bits 5:4 give unit size; 00 means one byte
// - mode word a bits 3:2 step the source pointer; 10 increments
// - mode word b bit 7 enables a chained transfer
// - mode word b bit 6 clear chains every time, but after a repeat reload only if allowed
// - mode word b bit 5 set raises cpu interrupt after every transfer that does not chain
// - mode word b bit 4 clear makes destination the block/repeat area
// - same vector and read skip set: skip vector and info fetch
// - after a chained activation, vector and info are always fetched
// - repeat mode reloads counter at zero; chain there only if allowed
// - short address mode sign-extends destination pointer from bit 23
// - vector base bits 31:28 and 11:0 stay zero; base of table
// - vector base resets to zero
// - system control bit 1 selects short address mode
// - module stop bit 12 blocks new activations while set
// - mode words, pointers and counters live in memory only
// - block end restores the down counter and the block area pointer
// - block counter zero clears source enable, then interrupts cpu
// - block mode splits first counter into size and down counter
// - info is read from memory, then written back after moving
//
// The AXI4-Lite register port was chosen for this implementation.
module event_triggered_transfer_ctrl
  import xfer_ctrl_pkg::*;
(
  input wire logic i_ref_clk, // system clock, 50 mhz
  input wire logic i_resetn, // synchronous reset, active low
  input wire logic [25:0] i_s_axi_awaddr, // write address
  input wire logic i_s_axi_awvalid, // write address valid
  output logic o_s_axi_awready, // write address ready
  input wire logic [31:0] i_s_axi_wdata, // write data
  input wire logic [3:0] i_s_axi_wstrb, // write byte strobes
  input wire logic i_s_axi_wvalid, // write data valid
  output logic o_s_axi_wready, // write data ready
  output logic [1:0] o_s_axi_bresp, // write response
  output logic o_s_axi_bvalid, // write response valid
  input wire logic i_s_axi_bready, // write response ready
  input wire logic [25:0] i_s_axi_araddr, // read address
  input wire logic i_s_axi_arvalid, // read address valid
  output logic o_s_axi_arready, // read address ready
  output logic [31:0] o_s_axi_rdata, // read data
  output logic [1:0] o_s_axi_rresp, // read response
  output logic o_s_axi_rvalid, // read data valid
  input wire logic i_s_axi_rready, // read data ready
  input wire logic i_act_req, // activation request level
  input wire logic [7:0] i_act_vector, // vector of the request
  output logic o_act_ack, // request taken, one cycle
  output vec_evt_t o_enable_clear, // clear source enable bit
  output vec_evt_t o_cpu_irq, // cpu interrupt request pulse
  output mem_req_t o_mem, // memory request, held to ack
  input wire logic i_mem_ack, // memory acknowledge pulse
  input wire logic [31:0] i_mem_rdata // read data, valid with ack
);

  // pointer step by unit size and step mode
  function automatic logic [31:0] step_ptr(input logic [31:0] p,
      input logic [1:0] md, input logic [1:0] sz);
    logic [31:0] n;
    n = (sz == SIZE_BYTE) ? 32'h1 : (sz == SIZE_WORD) ? 32'h2 : 32'h4;
    if (md == STEP_INC) begin
      step_ptr = p + n;
    end else if (md == STEP_DEC) begin
      step_ptr = p - n;
    end else begin
      step_ptr = p;
    end
  endfunction : step_ptr

  // short address mode pointer form
  function automatic logic [31:0] sx24(input logic [23:0] v);
    sx24 = {{8{v[23]}}, v};
  endfunction : sx24

  // register file and bus slave state
  logic [31:0] vbr_q, vbr_d;
  logic [15:0] sysc_q, sysc_d;
  logic [15:0] mstp_q, mstp_d;
  logic [7:0] tctl_q, tctl_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [23:0] aw_idx_q, aw_idx_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d;
  logic bvalid_q, bvalid_d, arrdy_q, arrdy_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // transfer engine state
  state_t st_q, st_d;
  logic [7:0] mra_q, mra_d, mrb_q, mrb_d;
  logic [31:0] sar_q, sar_d, dar_q, dar_d, sar0_q, sar0_d, dar0_q, dar0_d;
  logic [15:0] cra_q, cra_d, crb_q, crb_d;
  logic [31:0] info_q, info_d, data_q, data_d;
  logic [2:0] widx_q, widx_d;
  logic [7:0] vec_q, vec_d, last_vec_q, last_vec_d;
  logic info_ok_q, info_ok_d, chained_q, chained_d;
  logic last_chain_q, last_chain_d, reload_q, reload_d, end_q, end_d;
  logic ack_q, ack_d;
  vec_evt_t clr_q, clr_d, irq_q, irq_d;
  mem_req_t mem_q, mem_d;

  logic short_mode, stopped, skip, chain_go;
  logic [2:0] nwords;
  logic [31:0] wb_word, upd;

  assign short_mode = sysc_q[SHORT_ADDR_SELECT_BIT];
  assign stopped = mstp_q[CONTROLLER_STOP_BIT];
  assign nwords = short_mode ? INFO_WORDS_SHORT : INFO_WORDS_FULL;
  // skip fetch only for a repeated vector after a non-chained run
  assign skip = tctl_q[INFO_READ_SKIP_BIT] && info_ok_q &&
                (i_act_vector == last_vec_q) && !last_chain_q;
  // chain when enabled, unconditional or at count end, and not after a reload unless allowed
  assign chain_go = mrb_q[CHAIN_ENABLE_BIT] &&
                    (!mrb_q[CHAIN_CONDITION_BIT] || end_q) &&
                    (!reload_q || tctl_q[CHAIN_AFTER_RELOAD_BIT]);

  // info word written back at index widx_q
  always_comb begin
    wb_word = {cra_q, crb_q};
    if (short_mode) begin
      unique case (widx_q)
        3'd0: wb_word = {mra_q, sar_q[23:0]};
        3'd1: wb_word = {mrb_q, dar_q[23:0]};
        default: wb_word = {cra_q, crb_q};
      endcase
    end else begin
      unique case (widx_q)
        3'd0: wb_word = {mra_q, 24'h000000};
        3'd1: wb_word = sar_q;
        3'd2: wb_word = {mrb_q, 24'h000000};
        3'd3: wb_word = dar_q;
        default: wb_word = {cra_q, crb_q};
      endcase
    end
  end

  // bus slave next state, register writes and reads
  always_comb begin
    vbr_d = vbr_q;
    sysc_d = sysc_q;
    mstp_d = mstp_q;
    tctl_d = tctl_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_idx_d = aw_idx_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arrdy_d = arrdy_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    upd = 32'h0;
    if (awrdy_q && i_s_axi_awvalid) begin
      aw_have_d = 1'b1;
      aw_idx_d = i_s_axi_awaddr[25:2];
    end
    if (wrdy_q && i_s_axi_wvalid) begin
      w_have_d = 1'b1;
      w_data_d = i_s_axi_wdata;
      w_strb_d = i_s_axi_wstrb;
    end
    if (bvalid_q && i_s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        upd[8*b +: 8] = w_strb_q[b] ? w_data_q[8*b +: 8] : 8'h00;
      end
      unique case (aw_idx_q)
        VECTOR_BASE_IDX: begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b]) begin
              vbr_d[8*b +: 8] = upd[8*b +: 8];
            end
          end
          vbr_d = vbr_d & VECTOR_BASE_MASK;
        end
        SYSTEM_CONTROL_IDX: begin
          if (w_strb_q[0]) sysc_d[7:0] = upd[7:0];
          if (w_strb_q[1]) sysc_d[15:8] = upd[15:8];
        end
        MODULE_STOP_A_IDX: begin
          if (w_strb_q[0]) mstp_d[7:0] = upd[7:0];
          if (w_strb_q[1]) mstp_d[15:8] = upd[15:8];
        end
        TRANSFER_CONTROL_IDX: begin
          if (w_strb_q[0]) tctl_d = upd[7:0];
        end
        STATUS_IDX: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    awrdy_d = !aw_have_d && !bvalid_d;
    wrdy_d = !w_have_d && !bvalid_d;
    // reads; the info words are not in this map
    if (rvalid_q && i_s_axi_rready) begin
      rvalid_d = 1'b0;
      arrdy_d = 1'b1;
    end
    if (arrdy_q && i_s_axi_arvalid) begin
      arrdy_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (i_s_axi_araddr[25:2])
        VECTOR_BASE_IDX: rdata_d = vbr_q;
        SYSTEM_CONTROL_IDX: rdata_d = {16'h0000, sysc_q};
        MODULE_STOP_A_IDX: rdata_d = {16'h0000, mstp_q};
        TRANSFER_CONTROL_IDX: rdata_d = {24'h000000, tctl_q};
        STATUS_IDX: rdata_d = {12'h000, 1'b0, st_q, last_vec_q,
                               info_ok_q, last_chain_q, 6'h00};
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  // engine next state
  always_comb begin
    st_d = st_q;
    mra_d = mra_q;
    mrb_d = mrb_q;
    sar_d = sar_q;
    dar_d = dar_q;
    sar0_d = sar0_q;
    dar0_d = dar0_q;
    cra_d = cra_q;
    crb_d = crb_q;
    info_d = info_q;
    data_d = data_q;
    widx_d = widx_q;
    vec_d = vec_q;
    last_vec_d = last_vec_q;
    info_ok_d = info_ok_q;
    chained_d = chained_q;
    last_chain_d = last_chain_q;
    reload_d = reload_q;
    end_d = end_q;
    ack_d = 1'b0;
    clr_d = '0;
    irq_d = '0;
    mem_d = mem_q;
    unique case (st_q)
      ST_IDLE: begin
        if (i_act_req && !stopped) begin
          ack_d = 1'b1;
          vec_d = i_act_vector;
          chained_d = 1'b0;
          reload_d = 1'b0;
          end_d = 1'b0;
          if (skip) begin
            st_d = ST_XRD;
            mem_d = '{1'b1, 1'b0, mra_q[5:4], sar_q, 32'h0};
          end else begin
            st_d = ST_VEC;
            mem_d = '{1'b1, 1'b0, 2'b10,
                      vbr_q + {22'h0, i_act_vector, 2'b00}, 32'h0};
          end
        end
      end
      ST_VEC: begin
        if (i_mem_ack) begin
          info_d = i_mem_rdata;
          widx_d = 3'd0;
          st_d = ST_INFO;
          mem_d = '{1'b1, 1'b0, 2'b10, i_mem_rdata, 32'h0};
        end
      end
      ST_INFO: begin
        if (i_mem_ack) begin
          if (short_mode) begin
            unique case (widx_q)
              3'd0: begin
                mra_d = i_mem_rdata[31:24];
                sar_d = sx24(i_mem_rdata[23:0]);
              end
              3'd1: begin
                mrb_d = i_mem_rdata[31:24];
                dar_d = sx24(i_mem_rdata[23:0]);
              end
              default: {cra_d, crb_d} = i_mem_rdata;
            endcase
          end else begin
            unique case (widx_q)
              3'd0: mra_d = i_mem_rdata[31:24];
              3'd1: sar_d = i_mem_rdata;
              3'd2: mrb_d = i_mem_rdata[31:24];
              3'd3: dar_d = i_mem_rdata;
              default: {cra_d, crb_d} = i_mem_rdata;
            endcase
          end
          sar0_d = sar_d;
          dar0_d = dar_d;
          if (widx_q == nwords - 3'd1) begin
            info_ok_d = 1'b1;
            st_d = ST_XRD;
            mem_d = '{1'b1, 1'b0, mra_d[5:4], sar_d, 32'h0};
          end else begin
            widx_d = widx_q + 3'd1;
            mem_d.addr = mem_q.addr + 32'h4;
          end
        end
      end
      ST_XRD: begin
        if (i_mem_ack) begin
          data_d = i_mem_rdata;
          st_d = ST_XWR;
          mem_d = '{1'b1, 1'b1, mra_q[5:4], dar_q, i_mem_rdata};
        end
      end
      ST_XWR: begin
        if (i_mem_ack) begin
          sar_d = step_ptr(sar_q, mra_q[3:2], mra_q[5:4]);
          dar_d = step_ptr(dar_q, mrb_q[3:2], mra_q[5:4]);
          mem_d = '{1'b1, 1'b0, mra_q[5:4], sar_d, 32'h0};
          st_d = ST_WB;
          unique case (mra_q[7:6])
            MODE_BLOCK: begin
              cra_d[7:0] = cra_q[7:0] - 8'h1;
              if (cra_d[7:0] == 8'h00) begin
                cra_d[7:0] = cra_q[15:8];
                if (mrb_q[AREA_SIDE_SELECT_BIT]) begin
                  sar_d = sar0_q;
                end else begin
                  dar_d = dar0_q;
                end
                crb_d = crb_q - 16'h1;
                end_d = (crb_d == 16'h0000);
              end else begin
                st_d = ST_XRD;
              end
            end
            MODE_REPEAT: begin
              cra_d[7:0] = cra_q[7:0] - 8'h1;
              if (cra_d[7:0] == 8'h00) begin
                cra_d[7:0] = cra_q[15:8];
                reload_d = 1'b1;
                if (mrb_q[AREA_SIDE_SELECT_BIT]) begin
                  sar_d = sar0_q;
                end else begin
                  dar_d = dar0_q;
                end
              end
            end
            default: begin
              cra_d = cra_q - 16'h1;
              end_d = (cra_d == 16'h0000);
            end
          endcase
          if (st_d == ST_WB) begin
            widx_d = 3'd0;
            mem_d = '{1'b0, 1'b1, 2'b10, info_q, 32'h0};
          end
        end
      end
      ST_WB: begin
        mem_d.wdata = wb_word;
        mem_d.req = !i_mem_ack; // settle wdata first
        if (i_mem_ack) begin
          if (widx_q == nwords - 3'd1) begin
            mem_d.req = 1'b0;
            if (chain_go) begin
              chained_d = 1'b1;
              reload_d = 1'b0;
              end_d = 1'b0;
              widx_d = 3'd0;
              info_d = info_q + {27'h0, nwords, 2'b00};
              st_d = ST_INFO;
              mem_d = '{1'b1, 1'b0, 2'b10,
                        info_q + {27'h0, nwords, 2'b00}, 32'h0};
            end else begin
              st_d = ST_DONE;
              clr_d = '{end_q, vec_q};
            end
          end else begin
            widx_d = widx_q + 3'd1;
            mem_d.addr = mem_q.addr + 32'h4;
          end
        end
      end
      ST_DONE: begin
        irq_d = '{end_q || mrb_q[PER_TRANSFER_IRQ_BIT], vec_q};
        last_vec_d = vec_q;
        last_chain_d = chained_q;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
        mem_d = '0;
      end
    endcase
  end

  // registers of both groups
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      vbr_q <= VECTOR_BASE_RST;
      sysc_q <= SYSTEM_CONTROL_RST;
      mstp_q <= MODULE_STOP_A_RST;
      tctl_q <= TRANSFER_CONTROL_RST;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 24'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      awrdy_q <= 1'b0;
      wrdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arrdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
      st_q <= ST_IDLE;
      mra_q <= 8'h0;
      mrb_q <= 8'h0;
      sar_q <= 32'h0;
      dar_q <= 32'h0;
      sar0_q <= 32'h0;
      dar0_q <= 32'h0;
      cra_q <= 16'h0;
      crb_q <= 16'h0;
      info_q <= 32'h0;
      data_q <= 32'h0;
      widx_q <= 3'd0;
      vec_q <= 8'h0;
      last_vec_q <= 8'h0;
      info_ok_q <= 1'b0;
      chained_q <= 1'b0;
      last_chain_q <= 1'b0;
      reload_q <= 1'b0;
      end_q <= 1'b0;
      ack_q <= 1'b0;
      clr_q <= '0;
      irq_q <= '0;
      mem_q <= '0;
    end else begin
      vbr_q <= vbr_d;
      sysc_q <= sysc_d;
      mstp_q <= mstp_d;
      tctl_q <= tctl_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_idx_q <= aw_idx_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arrdy_q <= arrdy_d || (!rvalid_d && !arrdy_q && !rvalid_q);
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      mra_q <= mra_d;
      mrb_q <= mrb_d;
      sar_q <= sar_d;
      dar_q <= dar_d;
      sar0_q <= sar0_d;
      dar0_q <= dar0_d;
      cra_q <= cra_d;
      crb_q <= crb_d;
      info_q <= info_d;
      data_q <= data_d;
      widx_q <= widx_d;
      vec_q <= vec_d;
      last_vec_q <= last_vec_d;
      info_ok_q <= info_ok_d;
      chained_q <= chained_d;
      last_chain_q <= last_chain_d;
      reload_q <= reload_d;
      end_q <= end_d;
      ack_q <= ack_d;
      clr_q <= clr_d;
      irq_q <= irq_d;
      mem_q <= mem_d;
    end
  end

  // outputs straight from flops
  assign o_s_axi_awready = awrdy_q;
  assign o_s_axi_wready = wrdy_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_arready = arrdy_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rresp = rresp_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_act_ack = ack_q;
  assign o_enable_clear = clr_q;
  assign o_cpu_irq = irq_q;
  assign o_mem = mem_q;

endmodule : event_triggered_transfer_ctrl

// ---- bench/xfer_ctrl_checker.sv ----
// port checker for the transfer controller
// assumes a bind and a single clock
module xfer_ctrl_checker
  import xfer_ctrl_pkg::*;
(
  input wire logic i_ref_clk, // clock
  input wire logic i_resetn, // reset
  input wire logic [25:0] i_s_axi_araddr, // read addr
  input wire logic i_s_axi_arvalid, // addr valid
  input wire logic o_s_axi_arready, // addr ready
  input wire logic [31:0] o_s_axi_rdata, // read data
  input wire logic o_s_axi_rvalid, // data valid
  input wire logic i_s_axi_rready, // data ready
  input wire logic o_act_ack, // taken
  input wire vec_evt_t o_enable_clear, // clear pulse
  input wire vec_evt_t o_cpu_irq, // irq pulse
  input wire mem_req_t o_mem, // memory request
  input wire logic i_mem_ack // memory ack
);
  logic [23:0] ra_q; // index of the read in flight
  logic [23:0] ra_d;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // index of the read taken
  always_comb ra_d = (o_s_axi_arready && i_s_axi_arvalid) ?
    i_s_axi_araddr[25:2] : ra_q;
  always_ff @(posedge i_ref_clk) ra_q <= ra_d;
  chk_ack_req: assert property (o_act_ack |-> o_mem.req)
    else $error("no memory request at ack");
  chk_ack_once: assert property (o_act_ack |=> !o_act_ack)
    else $error("ack held too long");
  chk_read_first: assert property (o_act_ack |-> !o_mem.we)
    else $error("activation began with a write");
  chk_req_hold: assert property (o_mem.req && !i_mem_ack |=>
    o_mem.req && $stable(o_mem.addr) && $stable(o_mem.we))
    else $error("memory request changed before ack");
  chk_irq_after: assert property (o_enable_clear.valid |=>
    o_cpu_irq.valid && o_cpu_irq.vector == $past(o_enable_clear.vector))
    else $error("no cpu irq after enable clear");
  chk_irq_once: assert property (o_cpu_irq.valid |=>
    !o_cpu_irq.valid) else $error("irq held too long");
  chk_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
    |=> o_s_axi_rvalid) else $error("read not answered");
  chk_rd_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
  chk_base_zero: assert property (o_s_axi_rvalid &&
    ra_q == VECTOR_BASE_IDX |-> o_s_axi_rdata[31:28] == 4'h0 &&
    o_s_axi_rdata[11:0] == 12'h000) else $error("fixed base bits set");
  cov_clear: cover property (o_enable_clear.valid);
  cov_irq: cover property (o_cpu_irq.valid);
  cov_stall: cover property (o_mem.req && !i_mem_ack ##1 i_mem_ack);
endmodule : xfer_ctrl_checker
bind event_triggered_transfer_ctrl xfer_ctrl_checker xfer_ctrl_checker_i (
  .i_ref_clk, .i_resetn, .i_s_axi_araddr, .i_s_axi_arvalid,
  .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready,
  .o_act_ack, .o_enable_clear, .o_cpu_irq, .o_mem, .i_mem_ack);

// ---- bench/xfer_mem_model.sv ----
// memory partner answering the controller's bus requests
// assumes requests held to ack; answers after 0 to 3 stall cycles
module xfer_mem_model
  import xfer_ctrl_pkg::*;
(
  input wire logic i_clk, // clock
  input wire mem_req_t i_req, // request
  output logic o_ack, // one-cycle ack
  output logic [31:0] o_rdata // data with ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] m [logic [31:0]]; // one entry per byte address
  int reads [logic [31:0]]; // reads per address
  int stall = 0;
  logic [31:0] mask;
  initial {o_ack, o_rdata} = '0;
  // answer; idle data toggles so stale data is not trusted
  always @(posedge i_clk) begin
    mask = i_req.size == SIZE_BYTE ? 32'hff :
      i_req.size == SIZE_WORD ? 32'hffff : 32'hffffffff;
    o_ack <= 1'h0;
    o_rdata <= ~o_rdata;
    if (i_req.req === 1'h1 && !o_ack) begin
      if (stall > 0) stall--;
      else begin
        o_ack <= 1'h1;
        stall = $urandom_range(3);
        if (i_req.we) m[i_req.addr] = i_req.wdata & mask;
        else begin
          o_rdata <= m.exists(i_req.addr) ? m[i_req.addr] & mask : ~o_rdata;
          reads[i_req.addr]++;
        end
      end
    end
  end
endmodule : xfer_mem_model

// ---- bench/event_triggered_transfer_ctrl_test.sv ----
// self-checking bench for the event triggered transfer controller
// assumes the memory model and the bound checker
module event_triggered_transfer_ctrl_test import xfer_ctrl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = '0;
  logic i_resetn = '0;
  logic i_s_axi_awvalid = '0, i_s_axi_wvalid = '0, i_s_axi_bready = '0;
  logic i_s_axi_arvalid = '0, i_s_axi_rready = '0, i_act_req = '0;
  logic [25:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata, i_mem_rdata, rd;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic [7:0] i_act_vector = '0, v, irqv;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_act_ack, i_mem_ack, clr;
  logic [1:0] o_s_axi_bresp, rsp, rr;
  vec_evt_t o_enable_clear, o_cpu_irq;
  mem_req_t o_mem;
  logic [7:0] sq[$]; // source bytes in transfer order
  int mismatches = 0, tests_run = 0, cyc = 0, acks = 0;
  int src = 'h9a6, cnt = 2; // model of source pointer and block count
  event_triggered_transfer_ctrl event_triggered_transfer_ctrl_i (.i_ref_clk,
    .i_resetn, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp(rr),
    .o_s_axi_rvalid, .i_s_axi_rready, .i_act_req, .i_act_vector, .o_act_ack,
    .o_enable_clear, .o_cpu_irq, .o_mem, .i_mem_ack, .i_mem_rdata);
  xfer_mem_model xfer_mem_model_i (.i_clk(i_ref_clk), .i_req(o_mem),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  // 50 mhz clock
  initial forever #10 i_ref_clk = ~i_ref_clk;
  // drop a taken request, note clears, stop a hang
  always @(posedge i_ref_clk) begin
    cyc++;
    if (o_act_ack === 1'h1) begin
      i_act_req <= 1'h0;
      acks++;
    end
    if (o_enable_clear.valid === 1'h1) clr = 1'h1;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] mm(input logic [31:0] a);
    return xfer_mem_model_i.m[a];
  endfunction : mm
  // register write, both items offered together
  task automatic wr(input logic [23:0] idx, input logic [31:0] d);
    i_s_axi_awaddr <= {idx, 2'h0};
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    i_s_axi_bready <= 1'h1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
    end while (o_s_axi_bvalid !== 1'h1);
    i_s_axi_bready <= 1'h0;
    rsp = o_s_axi_bresp;
  endtask : wr
  task automatic rd_reg(input logic [23:0] idx);
    i_s_axi_araddr <= {idx, 2'h0};
    i_s_axi_arvalid <= 1'h1;
    i_s_axi_rready <= 1'h1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
    end while (o_s_axi_rvalid !== 1'h1);
    i_s_axi_rready <= 1'h0;
    rd = o_s_axi_rdata;
  endtask : rd_reg
  // raise an activation if asked, wait for its irq
  task automatic act(input logic up);
    clr = 1'h0;
    if (up) i_act_req <= 1'h1;
    i_act_vector <= v;
    do @(posedge i_ref_clk); while (o_cpu_irq.valid !== 1'h1);
    irqv = o_cpu_irq.vector;
  endtask : act
  // moved bytes and info against the model
  task automatic post();
    src += 2;
    cnt -= 1;
    chk(mm(32'hffffff50), {24'h0, sq.pop_front()});
    chk(mm(32'hffffff51), {24'h0, sq.pop_front()});
    chk(mm(32'h00ff5000), {8'h88, src[23:0]});
    chk(mm(32'h00ff5004), 32'h28ffff50);
    chk(mm(32'h00ff5008), {16'h0202, cnt[15:0]});
    chk(clr, cnt == 0);
    chk(irqv, v);
    $display("activation test done");
  endtask : post
  initial begin
    void'($urandom(85614));
    v = 8'($urandom_range(255));
    for (int i = 0; i < 6; i++) begin
      sq.push_back(8'($urandom));
      xfer_mem_model_i.m[32'h9a6 + i] = {24'h0, sq[i]};
    end
    xfer_mem_model_i.m[32'h3000 + 4 * v] = 32'h00ff5000;
    xfer_mem_model_i.m[32'h00ff5000] = 32'h880009a6;
    xfer_mem_model_i.m[32'h00ff5004] = 32'h28ffff50;
    xfer_mem_model_i.m[32'h00ff5008] = 32'h02020002;
    repeat (8) @(posedge i_ref_clk);
    i_resetn <= 1'h1;
    @(posedge i_ref_clk);
    rd_reg(VECTOR_BASE_IDX);
    chk(rd, VECTOR_BASE_RST);
    wr(VECTOR_BASE_IDX, 32'hffffffff);
    rd_reg(VECTOR_BASE_IDX);
    chk(rd, 32'h0ffff000);
    wr(TRANSFER_MODE_A_IDX, 32'h0);
    chk(rsp, RESP_SLVERR);
    rd_reg(TRANSFER_MODE_A_IDX);
    chk(rr, RESP_SLVERR);
    wr(VECTOR_BASE_IDX, 32'h00003000);
    wr(SYSTEM_CONTROL_IDX, 32'h00000002);
    $display("register test done");
    act(1'h1);
    post();
    wr(TRANSFER_CONTROL_IDX, 32'h00000010);
    act(1'h1);
    chk(xfer_mem_model_i.reads[32'h00ff5000], 1);
    post();
    wr(MODULE_STOP_A_IDX, 32'h00001000);
    acks = 0;
    i_act_req <= 1'h1;
    repeat (20) @(posedge i_ref_clk);
    chk(acks, 0);
    wr(MODULE_STOP_A_IDX, 32'h0);
    act(1'h0);
    post();
    end_sim();
  end
endmodule : event_triggered_transfer_ctrl_test
